// File: verilog/tcpwm_channels.sv
// How it works
// R1: Unbuffered channel compares counter straight against its written value.
// R2: Compare fires only on equality; a passed new value gives no compare.
// R3: Link bit in channel 0 control joins both channels as a buffered pair.
// R4: Channel 0 value rules first; a channel 1 write takes over at next wrap.
// R5: At each wrap the most recently written channel value becomes active.
// R6: Buffered output drives the channel 0 pin.
// R7: Linked: channel 0 control governs, channel 1 pin released.
// R8: Toggle-on-overflow flips the pin when the counter rolls from the period limit to zero.
// R9: Pulse runs from wrap to the compare match.
// R10: Counter runs zero through period limit inclusive.
// R11: Compare event sets the channel flag.
// R12: Each wrap sets the wrap flag.
// R13: Software lowers unbuffered values from the compare handler.
// R14: Software raises unbuffered values from the wrap handler.
// R15: Software never writes the active buffered channel value.
// R16: Software sets compare action opposite the pulse level, never toggle.
// R17: Mode pair 01 unbuffered, 10 buffered.
// R18: Edge pair 10 clears, 11 sets on compare.
// R19: Software halts, resets, programs, then releases the counter.
// R20: Toggle off gives 0% duty; with full duty force gives 100%.
// R21: Link bit outranks the other mode bit.
// R22: Wrap flag sets when counter rolls to zero after the limit.
// R23: Counter reset clears counter and prescaler, reads zero.
// R24: One compare per period, in the tick that steps the counter onto the value.
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module tcpwm_channels
	import tcpwm_pkg::*;
(
	input logic clk_in,
	input logic rst_b_in,
	input logic wb_cyc_in,
	input logic wb_stb_in,
	input logic wb_we_in,
	input logic [9:0] wb_adr_in,
	input logic [3:0] wb_sel_in,
	input logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input logic ext_clk_pin_in,
	output logic chan0_pin_out,
	output logic chan0_pin_oe_out,
	output logic chan1_pin_out,
	output logic chan1_pin_oe_out
);
	typedef struct packed {
		logic [7:0] tsc;
		logic [15:0] cnt;
		logic [15:0] plimit;
		logic [1:0][7:0] csc;
		logic [1:0][15:0] cval;
		logic wrap_arm;
		logic [1:0] ch_arm;
		tcpwm_sel_t act_sel;
		tcpwm_sel_t last_sel;
		logic [1:0] pin;
		logic [1:0] pin_oe;
		logic ack;
		logic [31:0] rdat;
	} tcpwm_state_t;

	localparam tcpwm_state_t STATE_RST = '{
		tsc: TSC_RST,
		cnt: 16'h0000,
		plimit: PLIMIT_RST,
		csc: {CSC_RST, CSC_RST},
		cval: {CVAL_RST, CVAL_RST},
		wrap_arm: 1'b0,
		ch_arm: 2'b00,
		act_sel: SEL_CH0,
		last_sel: SEL_CH0,
		pin: 2'b00,
		pin_oe: 2'b00,
		ack: 1'b0,
		rdat: 32'h0000_0000
	};

	tcpwm_state_t s_q;
	tcpwm_state_t s_d;

	logic tick;
	logic access;
	logic wr;
	logic rd;
	logic [7:0] idx;
	logic [7:0] wdat;
	logic crst;
	logic link;
	logic [1:0] chan_en;
	logic [15:0] val0;
	logic [1:0] match;
	logic wrap;
	logic [15:0] cnt_nxt;

	// Next pin level from one period event and one compare event
	function automatic logic pin_next(
		input logic cur,
		input logic [7:0] ctl,
		input logic wrap_ev,
		input logic match_ev
	);
		logic r;
		r = cur;
		if (wrap_ev)
		begin
			// R8: overflow toggle
			if (ctl[TOV_BIT])
				r = ~cur;
			// R20: full duty holds the pulse level
			else if (ctl[MAXD_BIT])
				r = ~ctl[ELSL_BIT];
		end
		// R20: with full duty set and toggle off a compare is ignored
		if (match_ev && !(ctl[MAXD_BIT] && !ctl[TOV_BIT]))
		begin
			// R18: edge/level action
			unique case (ctl[ELSH_BIT:ELSL_BIT])
				ELS_TOGGLE: r = ~r;
				ELS_CLEAR: r = 1'b0;
				ELS_SET: r = 1'b1;
				ELS_NONE: r = r;
			endcase
		end
		return r;
	endfunction

	// Channel enable for output compare from its mode pair
	function automatic logic mode_is_compare(input logic [1:0] mode);
		return (mode == MODE_UNBUF) || mode[1];
	endfunction

	tcpwm_tick u_tick (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.ext_clk_pin_in(ext_clk_pin_in),
		.prescale_in(s_q.tsc[PS_MSB:0]),
		.halt_in(s_q.tsc[HALT_BIT]),
		.clear_in(crst),
		.tick_out(tick)
	);

	// Single wait state: answer one cycle after the request is seen
	assign access = wb_cyc_in & wb_stb_in & ~s_q.ack;
	assign wr = access & wb_we_in & wb_sel_in[0];
	assign rd = access & ~wb_we_in;
	assign idx = wb_adr_in[9:2];
	assign wdat = wb_dat_in[7:0];

	// R23: write-only reset strobe, clears prescaler too
	assign crst = wr && (idx == TSC_IDX) && wdat[CRST_BIT];

	// R3: link bit joins the pair
	assign link = s_q.csc[0][LINK_BIT];

	// R21: link bit outranks the low mode bit
	// R17: mode pair decode
	assign chan_en[0] = mode_is_compare({link, s_q.csc[0][MSL_BIT]});
	// R7: channel 1 idle while linked
	assign chan_en[1] = ~link & mode_is_compare({1'b0, s_q.csc[1][MSL_BIT]});

	// R1: unbuffered compares the written value directly
	// R4: linked pair picks the active channel value
	assign val0 = (link && s_q.act_sel == SEL_CH1) ? s_q.cval[1] : s_q.cval[0];

	// R10: period ends on the limit value inclusive
	assign wrap = tick && (s_q.cnt == s_q.plimit);

	// Count the tick steps onto, so a value of n gives a pulse of n ticks
	assign cnt_nxt = wrap ? 16'h0000 : s_q.cnt + 16'h0001;

	// R2: equality only, no catch-up for passed values
	// R24: one match per period, as the counter reaches the value
	assign match[0] = tick & chan_en[0] & (cnt_nxt == val0);
	assign match[1] = tick & chan_en[1] & (cnt_nxt == s_q.cval[1]);

	always_comb
	begin
		s_d = s_q;
		s_d.ack = access;
		if (rd)
		begin
			s_d.rdat = 32'h0000_0000;
			unique case (idx)
				TSC_IDX:
				begin
					s_d.rdat[7:0] = s_q.tsc;
					s_d.wrap_arm = s_q.tsc[FLAG_BIT];
				end
				CNTH_IDX: s_d.rdat[7:0] = s_q.cnt[15:8];
				CNTL_IDX: s_d.rdat[7:0] = s_q.cnt[7:0];
				PLH_IDX: s_d.rdat[7:0] = s_q.plimit[15:8];
				PLL_IDX: s_d.rdat[7:0] = s_q.plimit[7:0];
				C0SC_IDX:
				begin
					s_d.rdat[7:0] = s_q.csc[0];
					s_d.ch_arm[0] = s_q.csc[0][FLAG_BIT];
				end
				C0VH_IDX: s_d.rdat[7:0] = s_q.cval[0][15:8];
				C0VL_IDX: s_d.rdat[7:0] = s_q.cval[0][7:0];
				C1SC_IDX:
				begin
					s_d.rdat[7:0] = s_q.csc[1];
					s_d.ch_arm[1] = s_q.csc[1][FLAG_BIT];
				end
				C1VH_IDX: s_d.rdat[7:0] = s_q.cval[1][15:8];
				C1VL_IDX: s_d.rdat[7:0] = s_q.cval[1][7:0];
				default: s_d.rdat = 32'h0000_0000;
			endcase
		end
		if (wr)
		begin
			unique case (idx)
				TSC_IDX:
				begin
					s_d.tsc[IE_BIT] = wdat[IE_BIT];
					s_d.tsc[HALT_BIT] = wdat[HALT_BIT];
					s_d.tsc[PS_MSB:0] = wdat[PS_MSB:0];
					// Writing zero clears only after a read saw the flag set
					if (s_q.wrap_arm && !wdat[FLAG_BIT])
						s_d.tsc[FLAG_BIT] = 1'b0;
					s_d.wrap_arm = 1'b0;
				end
				PLH_IDX: s_d.plimit[15:8] = wdat;
				PLL_IDX: s_d.plimit[7:0] = wdat;
				C0SC_IDX:
				begin
					s_d.csc[0][6:0] = wdat[6:0];
					if (s_q.ch_arm[0] && !wdat[FLAG_BIT])
						s_d.csc[0][FLAG_BIT] = 1'b0;
					s_d.ch_arm[0] = 1'b0;
				end
				C0VH_IDX:
				begin
					s_d.cval[0][15:8] = wdat;
					s_d.last_sel = SEL_CH0;
				end
				C0VL_IDX:
				begin
					s_d.cval[0][7:0] = wdat;
					s_d.last_sel = SEL_CH0;
				end
				C1SC_IDX:
				begin
					s_d.csc[1][6:0] = wdat[6:0];
					// Channel 1 has no link bit
					s_d.csc[1][LINK_BIT] = 1'b0;
					if (s_q.ch_arm[1] && !wdat[FLAG_BIT])
						s_d.csc[1][FLAG_BIT] = 1'b0;
					s_d.ch_arm[1] = 1'b0;
				end
				C1VH_IDX:
				begin
					s_d.cval[1][15:8] = wdat;
					s_d.last_sel = SEL_CH1;
				end
				C1VL_IDX:
				begin
					s_d.cval[1][7:0] = wdat;
					s_d.last_sel = SEL_CH1;
				end
				default: s_d.cval = s_d.cval;
			endcase
		end

		// R23: counter reset beats the count, halt then pins it at zero
		if (crst)
			s_d.cnt = 16'h0000;
		// R22: roll to zero after the limit
		else if (wrap)
			s_d.cnt = 16'h0000;
		else if (tick)
			s_d.cnt = s_q.cnt + 16'h0001;

		// R12: wrap flag, set wins over a clear in the same cycle
		if (wrap)
		begin
			s_d.tsc[FLAG_BIT] = 1'b1;
			s_d.wrap_arm = 1'b0;
		end
		// R11: compare flag, set wins over a clear
		for (int c = 0; c < 2; c++)
		begin
			if (match[c])
			begin
				s_d.csc[c][FLAG_BIT] = 1'b1;
				s_d.ch_arm[c] = 1'b0;
			end
		end

		// Unlinked pair always restarts on channel 0
		if (!link)
		begin
			s_d.act_sel = SEL_CH0;
			s_d.last_sel = SEL_CH0;
		end
		// R5: hand over to the last written channel at each wrap
		else if (wrap)
		begin
			unique case (s_q.last_sel)
				SEL_CH0: s_d.act_sel = SEL_CH0;
				SEL_CH1: s_d.act_sel = SEL_CH1;
			endcase
		end

		// R6: buffered output uses the channel 0 pin
		// R9: pulse from wrap to match
		for (int c = 0; c < 2; c++)
		begin
			if (chan_en[c])
				s_d.pin[c] = pin_next(s_q.pin[c], s_q.csc[c], wrap, match[c]);
			// R7: released pins are not driven
			s_d.pin_oe[c] = chan_en[c] &&
				(s_q.csc[c][ELSH_BIT:ELSL_BIT] != ELS_NONE);
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			s_q <= STATE_RST;
		else
			s_q <= s_d;
	end

	assign wb_dat_out = s_q.rdat;
	assign wb_ack_out = s_q.ack;
	assign chan0_pin_out = s_q.pin[0];
	assign chan0_pin_oe_out = s_q.pin_oe[0];
	assign chan1_pin_out = s_q.pin[1];
	assign chan1_pin_oe_out = s_q.pin_oe[1];
endmodule // tcpwm_channels

// File: verilog/tcpwm_pkg.sv
package tcpwm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] TSC_IDX = 8'h40;
	localparam logic [7:0] CNTH_IDX = 8'h41;
	localparam logic [7:0] CNTL_IDX = 8'h42;
	localparam logic [7:0] PLH_IDX = 8'h43;
	localparam logic [7:0] PLL_IDX = 8'h44;
	localparam logic [7:0] C0SC_IDX = 8'h45;
	localparam logic [7:0] C0VH_IDX = 8'h46;
	localparam logic [7:0] C0VL_IDX = 8'h47;
	localparam logic [7:0] C1SC_IDX = 8'h48;
	localparam logic [7:0] C1VH_IDX = 8'h49;
	localparam logic [7:0] C1VL_IDX = 8'h4a;

	// timer_status_control fields
	localparam int FLAG_BIT = 7;
	localparam int IE_BIT = 6;
	localparam int HALT_BIT = 5;
	localparam int CRST_BIT = 4;
	localparam int PS_MSB = 2;

	// Channel status/control fields
	localparam int LINK_BIT = 5;
	localparam int MSL_BIT = 4;
	localparam int ELSH_BIT = 3;
	localparam int ELSL_BIT = 2;
	localparam int TOV_BIT = 1;
	localparam int MAXD_BIT = 0;

	localparam logic [7:0] TSC_RST = 8'h20;
	localparam logic [7:0] CSC_RST = 8'h00;
	localparam logic [15:0] PLIMIT_RST = 16'hffff;
	localparam logic [15:0] CVAL_RST = 16'h0000;

	// Mode select pair {high, low}
	localparam logic [1:0] MODE_UNBUF = 2'b01;
	localparam logic [1:0] MODE_BUF = 2'b10;
	// Edge/level select pair {high, low}
	localparam logic [1:0] ELS_NONE = 2'b00;
	localparam logic [1:0] ELS_TOGGLE = 2'b01;
	localparam logic [1:0] ELS_CLEAR = 2'b10;
	localparam logic [1:0] ELS_SET = 2'b11;

	localparam logic [2:0] PS_EXT = 3'b111;
	localparam int DIV_W = 6;

	typedef enum logic [1:0] {
		SEL_CH0 = 2'b01,
		SEL_CH1 = 2'b10
	} tcpwm_sel_t;
endpackage

// File: verilog/tcpwm_tick.sv
`timescale 1ns/1ps
module tcpwm_tick
	import tcpwm_pkg::*;
(
	input logic clk_in,
	input logic rst_b_in,
	input logic ext_clk_pin_in,
	input logic [2:0] prescale_in,
	input logic halt_in,
	input logic clear_in,
	output logic tick_out
);
	typedef struct packed {
		logic [1:0] sync;
		logic ext_prev;
		logic [DIV_W-1:0] div;
		logic tick;
	} tcpwm_tick_t;

	tcpwm_tick_t s_q;
	tcpwm_tick_t s_d;

	always_comb
	begin
		logic [DIV_W-1:0] mask;
		mask = DIV_W'((7'h01 << prescale_in) - 7'h01);
		s_d = s_q;
		s_d.sync = {s_q.sync[0], ext_clk_pin_in};
		s_d.ext_prev = s_q.sync[1];
		s_d.tick = 1'b0;
		if (clear_in)
		begin
			s_d.div = '0;
		end
		else if (!halt_in)
		begin
			if (prescale_in == PS_EXT)
			begin
				// Rising edge of the synchronised pin only
				s_d.tick = s_q.sync[1] & ~s_q.ext_prev;
			end
			else
			begin
				s_d.div = s_q.div + DIV_W'(1);
				s_d.tick = ((s_q.div & mask) == mask);
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick_out = s_q.tick;
endmodule // tcpwm_tick

// File: tb/tcpwm_channels_asserts.sv
`timescale 1ns/1ps
module tcpwm_channels_asserts
	import tcpwm_pkg::*;
(
	input logic clk_in,
	input logic rst_b_in,
	input logic wb_cyc_in,
	input logic wb_stb_in,
	input logic wb_we_in,
	input logic [9:0] wb_adr_in,
	input logic [3:0] wb_sel_in,
	input logic [31:0] wb_dat_in,
	input logic [31:0] wb_dat_out,
	input logic wb_ack_out,
	input logic ext_clk_pin_in,
	input logic chan0_pin_out,
	input logic chan0_pin_oe_out,
	input logic chan1_pin_out,
	input logic chan1_pin_oe_out
);
	logic req;
	logic [7:0] idx;
	assign req = wb_cyc_in && wb_stb_in;
	assign idx = wb_adr_in[9:2];
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held past one cycle");
	ack_answer_a: assert property ((req && !wb_ack_out) |=> wb_ack_out)
		else $error("request not answered next cycle");
	ack_cause_a: assert property (wb_ack_out |-> $past(req))
		else $error("ack without request");
	dat_high_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
		else $error("upper read data not zero");
	unmap_zero_a: assert property ((wb_ack_out && $past(!wb_we_in
		&& (idx < TSC_IDX || idx > C1VL_IDX))) |-> wb_dat_out == 32'h0)
		else $error("unmapped read not zero");
	crst_zero_a: assert property ((wb_ack_out && $past(!wb_we_in && idx == TSC_IDX))
		|-> !wb_dat_out[CRST_BIT])
		else $error("counter reset bit read as one");
	c1_link_a: assert property ((wb_ack_out && $past(!wb_we_in && idx == C1SC_IDX))
		|-> !wb_dat_out[LINK_BIT])
		else $error("channel 1 link bit read as one");
	oe0_cause_a: assert property ($changed(chan0_pin_oe_out)
		|-> $past(req && wb_we_in) || $past(req && wb_we_in, 2))
		else $error("channel 0 drive changed without write");
	oe1_cause_a: assert property ($changed(chan1_pin_oe_out)
		|-> $past(req && wb_we_in) || $past(req && wb_we_in, 2))
		else $error("channel 1 drive changed without write");
	cover property (wb_ack_out && !$past(wb_we_in));
	cover property ($rose(chan0_pin_out));
	cover property ($fell(chan0_pin_out) ##[1:300] $rose(chan0_pin_out));
endmodule // tcpwm_channels_asserts
bind tcpwm_channels tcpwm_channels_asserts tcpwm_channels_asserts_i (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
	.wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
	.wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.ext_clk_pin_in(ext_clk_pin_in), .chan0_pin_out(chan0_pin_out),
	.chan0_pin_oe_out(chan0_pin_oe_out), .chan1_pin_out(chan1_pin_out),
	.chan1_pin_oe_out(chan1_pin_oe_out));

// File: tb/tcpwm_load.sv
`timescale 1ns/1ps
module tcpwm_load (
	input logic clk_in,
	input logic pin_in,
	input logic oe_in,
	output logic wire_out,
	output logic [15:0] high_out,
	output logic [15:0] per_out
);
	logic lvl_q;
	logic [15:0] t_q;
	// Released pin sinks to the pull-down
	assign wire_out = oe_in ? pin_in : 1'b0;
	// Times from rise to fall and rise to rise
	always_ff @(posedge clk_in)
	begin
		lvl_q <= wire_out;
		t_q <= (wire_out && !lvl_q) ? 16'h0001 : t_q + 16'h0001;
		if (wire_out && !lvl_q)
			per_out <= t_q;
		if (!wire_out && lvl_q)
			high_out <= t_q;
	end
endmodule // tcpwm_load

// File: tb/tcpwm_channels_tb_top.sv
`timescale 1ns/1ps
module tcpwm_channels_tb_top;
	import tcpwm_pkg::*;
	logic clk_in = 0;
	logic rst_b_in = 0;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic [9:0] adr = 10'h000;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic ack, p0, p0oe, p1, p1oe, w0;
	logic [15:0] hi, per;
	int n_mismatch = 0;
	int comparisons = 0;
	tcpwm_channels tcpwm_channels_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1),
		.wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack), .ext_clk_pin_in(1'b0),
		.chan0_pin_out(p0), .chan0_pin_oe_out(p0oe), .chan1_pin_out(p1),
		.chan1_pin_oe_out(p1oe));
	tcpwm_load tcpwm_load_i (.clk_in(clk_in), .pin_in(p0), .oe_in(p0oe), .wire_out(w0),
		.high_out(hi), .per_out(per));
	initial
	begin
		forever #12.5 clk_in = ~clk_in;
	end
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {a, 2'b00};
		dat <= {24'h0, d};
		do @(posedge clk_in); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		comparisons++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string n);
		acc(0, a, 8'h00);
		chk(n, {8'h00, e}, q[15:0]);
	endtask
	task end_of_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#500000;
		n_mismatch++;
		end_of_test;
	end
	initial
	begin
		repeat (8) @(posedge clk_in);
		rst_b_in <= 1;
		rd(TSC_IDX, TSC_RST, "tsc");
		rd(PLL_IDX, 8'hff, "pll");
		rd(C0SC_IDX, CSC_RST, "c0sc");
		rd(8'h3f, 8'h00, "unmap");
		// Halt, program, then release
		acc(1, TSC_IDX, 8'h30);
		acc(1, PLH_IDX, 8'h00);
		acc(1, PLL_IDX, 8'hff);
		acc(1, C0VH_IDX, 8'h00);
		acc(1, C0VL_IDX, 8'h80);
		acc(1, C0SC_IDX, 8'h1a);
		acc(1, TSC_IDX, 8'h00);
		repeat (600) @(posedge clk_in);
		chk("period", 16'd256, per);
		chk("pulse", 16'd128, hi);
		rd(TSC_IDX, 8'h80, "wrap");
		rd(C0SC_IDX, 8'h9a, "c0flag");
		acc(1, C0SC_IDX, 8'h1a);
		do acc(0, C0SC_IDX, 8'h00); while (q[7] !== 1'b1);
		// Shorter pulse written just after the compare
		acc(1, C0VL_IDX, 8'h60);
		repeat (600) @(posedge clk_in);
		chk("lower", 16'd96, hi);
		acc(0, TSC_IDX, 8'h00);
		acc(1, TSC_IDX, 8'h00);
		do acc(0, TSC_IDX, 8'h00); while (q[7] !== 1'b1);
		// Longer pulse written just after the wrap
		acc(1, C0VL_IDX, 8'h80);
		repeat (600) @(posedge clk_in);
		chk("raise", 16'd128, hi);
		acc(1, C0SC_IDX, 8'h3a);
		acc(1, C1VL_IDX, 8'h40);
		repeat (600) @(posedge clk_in);
		chk("buf1", 16'd64, hi);
		chk("c1oe", 16'h0, {15'h0, p1oe});
		chk("c1pin", 16'h0, {15'h0, p1});
		acc(1, C0VL_IDX, 8'h20);
		repeat (600) @(posedge clk_in);
		chk("buf0", 16'd32, hi);
		acc(1, C1SC_IDX, 8'h20);
		rd(C1SC_IDX, 8'h00, "c1sc");
		acc(1, C0SC_IDX, 8'h18);
		repeat (600) @(posedge clk_in);
		chk("duty0", 16'h0, {15'h0, w0});
		acc(1, C0SC_IDX, 8'h19);
		repeat (600) @(posedge clk_in);
		chk("duty100", 16'h1, {15'h0, w0});
		acc(1, TSC_IDX, 8'h30);
		rd(CNTL_IDX, 8'h00, "cntl");
		rd(CNTH_IDX, 8'h00, "cnth");
		rd(PLL_IDX, 8'hff, "pll2");
		rd(TSC_IDX, 8'ha0, "tsc2");
		acc(1, TSC_IDX, 8'h20);
		rd(TSC_IDX, 8'h20, "flagclr");
		end_of_test;
	end
endmodule // tcpwm_channels_tb_top
